// ### frp_code_a_calc.v
/*
  Precompensation delay calculator: turns code and rate into a delay in 10 ps units.
  Assumes inputs are registered values from the same clock domain.
*/
`timescale 1ns/1ps
module frp_code_a_calc
(
  // Selection.
  input wire [2:0] code,
  input wire [1:0] rateSel,
  input wire tapeRate,
  // Result.
  output reg [15:0] delayPs,
  output reg precompOn
);

`include "frp_defines.vh"

reg [15:0] step;
reg [18:0] prod;

always @*
begin
  step = tapeRate ? `FRP_STEP_TAPE_PS : `FRP_STEP_PS;
  prod = {3'h0, step} * {16'h0000, code};
  precompOn = 1'b1;
  delayPs = 16'h0000;
  if (code == `FRP_PC_OFF)
  begin
    precompOn = 1'b0; // [RULE10]
  end
  else if (code == `FRP_PC_DEFAULT)
  begin
    // Default depends on rate; tape and 1 MB/s take one step.
    if (tapeRate || rateSel == `FRP_RATE_1M)
      delayPs = step; // [RULE10]
    else
      delayPs = `FRP_DEF_LOW_PS; // [RULE10]
  end
  else
  begin
    delayPs = prod[15:0]; // [RULE9]
  end
end

endmodule // frp_code_a_calc

// ### frp_defines.vh
/*
  Constants for the rate, precompensation and data port register block.
  Assumes a 10 MHz system clock and a plain strobe register port.
*/
`ifndef FRP_DEFINES_VH
`define FRP_DEFINES_VH

// Register offsets.
`define FRP_OFF_RATE 3'h4
`define FRP_OFF_DATA 3'h5
`define FRP_OFF_CFGCC 3'h7
`define FRP_OFF_STAT0 3'h6
`define FRP_OFF_CTRL 3'h3

// Rate control fields.
`define FRP_RST_BIT 7
`define FRP_PD_BIT 6
`define FRP_PC_HI 4
`define FRP_PC_LO 2
`define FRP_RATE_HI 1
`define FRP_RATE_LO 0
`define FRP_RATE_RESET 8'h02

// Rate codes.
`define FRP_RATE_500 2'h0
`define FRP_RATE_300 2'h1
`define FRP_RATE_250 2'h2
`define FRP_RATE_1M 2'h3
`define FRP_DRT_TAPE 2'h2

// Precompensation codes.
`define FRP_PC_DEFAULT 3'h0
`define FRP_PC_OFF 3'h7

// Delays count 10 ps units, so that the longest step product of 250 ns fits in 16 bits.
`define FRP_STEP_PS 16'h1047
`define FRP_STEP_TAPE_PS 16'h0823
`define FRP_DEF_LOW_PS 16'h30d4

// Status zero interrupt codes.
`define FRP_IC_NORMAL 2'h0
`define FRP_IC_ABNORMAL 2'h1
`define FRP_IC_INVALID 2'h2
`define FRP_IC_RDYCHG 2'h3

// Equipment check step limit.
`define FRP_STEP_LIMIT 7'h4d

// Data port stack depth and index width.
`define FRP_STACK_DEPTH 4
`define FRP_STACK_AW 2

`endif

// ### frp_drive_model.sv
/*
  Behavioural floppy drive: head position, track zero, ready and fault pins.
  Assumes step pulses move the head one track toward track zero.
*/
`timescale 1ns/1ps
module frp_drive_model
(
  // Clock and drive control.
  input wire clk_sys,
  input wire stepPulse,
  input wire [1:0] unitSel,
  // Drive status pins.
  output reg driveReady,
  output reg driveFault,
  output reg trackZero
);
  reg [6:0] track = 7'h05;
  // Drive D is left unfitted, so selecting it reports a fault.
  always @(posedge clk_sys)
  begin
    if (stepPulse && track != 7'h00)
      track <= track - 7'h01;
    trackZero <= (track == 7'h00);
    driveReady <= (unitSel != 2'h3);
    driveFault <= (unitSel == 2'h3);
  end
endmodule // frp_drive_model

// ### frp_rate_regs.v
/*
  Host register block: rate and precompensation control, data port with a four-deep
  status stack, status register zero layout and main status readback.
  Assumes a single 10 MHz clock, a strobe register port driven on that clock,
  and drive status pins that are asynchronous and need synchronising.
*/
// Design decision made here: the strobed register port.
// Operation
// [RULE1] Write-only rate control register at offset 4 sets rate and precompensation.
// [RULE2] Effective rate follows whichever of rate or config register was written last; the code does so only with compatMode set, else the rate register decides.
// [RULE3] Writing one to bit 7 triggers a software reset.
// [RULE4] Bit 6 selects normal operation or power-down.
// [RULE5] Bits 4 to 2 select the precompensation delay code.
// [RULE6] Bits 1-0 select the data rate among four codes.
// [RULE7] Reduced write current is high for codes 00 and 11, low otherwise.
// [RULE8] Tape 2 MB/s only with rate code 01 and drive-rate config 10.
// [RULE9] Codes 001 to 110 step 41.67 ns; halved at the tape rate.
// [RULE10] Code 000 gives the rate default delay; code 111 disables precompensation.
// [RULE11] Data port at offset 5 presents one of four stacked status bytes.
// [RULE12] Data port is disabled after reset until configured.
// [RULE13] Status zero bits 7-6 hold the interrupt code.
// [RULE14] Equipment check set on drive fault or no track zero after 77 steps.
// [RULE15] Status zero bit 3 is not ready; bit 5 is seek end.
// [RULE16] Status zero bit 2 is the current head address.
// [RULE17] Status zero bits 1-0 encode the selected drive.
// [RULE18] A read at offset 4 returns the main status register.
// [RULE19] Reserved bit 5 is ignored; settings hold until next write or reset.
// [RULE20] Master reset returns rate control to code 10 with other bits clear.
`timescale 1ns/1ps
module frp_rate_regs
(
  // Clock and reset.
  input wire clk_sys,
  input wire arst_n,
  // Register port.
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  // Compatibility mode and drive-rate configuration.
  input wire compatMode,
  input wire [1:0] driveRateCfg,
  // Command engine side.
  input wire [1:0] intCode,
  input wire seekDone,
  input wire seekOk,
  input wire stepPulse,
  input wire resultPush,
  input wire [7:0] resultByte,
  input wire cmdStart,
  input wire engineBusy,
  input wire [1:0] unitSel,
  input wire headSel,
  // Drive pins.
  input wire driveFault,
  input wire driveReady,
  input wire trackZero,
  // Outputs.
  output reg reduced_write_current_n,
  output reg [1:0] rateSelect,
  output reg tapeRateOn,
  output reg powerDown,
  output reg softReset,
  output reg [15:0] precompDelayPs,
  output reg precompEnable,
  output reg [7:0] cmdByte,
  output reg cmdValid
);

`include "frp_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Address decode shared by read and write paths.

function isAddr;
  input [2:0] addr;
  input [2:0] off;
  begin
    isAddr = (addr == off);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers; only the second stage is read.

reg [2:0] pinMeta;
reg [2:0] pinSync;

always @(posedge clk_sys or negedge arst_n)
begin
  if (!arst_n)
  begin
    pinMeta <= 3'h0;
    pinSync <= 3'h0;
  end
  else
  begin
    pinMeta <= {driveFault, driveReady, trackZero};
    pinSync <= pinMeta;
  end
end

wire faultS = pinSync[2];
wire readyS = pinSync[1];
wire trackZeroS = pinSync[0];

////////////////////////////////////////////////////////////////////////////////
// Rate control and configuration control registers.

reg [2:0] codeA;
reg [1:0] rateReg;
reg [1:0] ccRate;
reg ccLast;
reg fifoEnable;

wire wrRate = regWr && isAddr(regAddr, `FRP_OFF_RATE); // [RULE1]
wire wrCc = regWr && isAddr(regAddr, `FRP_OFF_CFGCC);
wire wrCtrl = regWr && isAddr(regAddr, `FRP_OFF_CTRL);

always @(posedge clk_sys or negedge arst_n)
begin
  if (!arst_n)
  begin
    rateReg <= `FRP_RATE_250; // [RULE20]
    codeA <= `FRP_PC_DEFAULT; // [RULE20]
    powerDown <= 1'b0; // [RULE20]
    softReset <= 1'b0; // [RULE20]
    ccRate <= `FRP_RATE_250;
    ccLast <= 1'b0;
    fifoEnable <= 1'b0; // [RULE12]
  end
  else
  begin
    // Software reset is a one-cycle pulse so it never sticks.
    softReset <= wrRate && regWdata[`FRP_RST_BIT]; // [RULE3]
    if (wrRate)
    begin
      powerDown <= regWdata[`FRP_PD_BIT]; // [RULE4]
      codeA <= regWdata[`FRP_PC_HI:`FRP_PC_LO]; // [RULE5] [RULE19]
      rateReg <= regWdata[`FRP_RATE_HI:`FRP_RATE_LO]; // [RULE6]
      ccLast <= 1'b0; // [RULE2]
    end
    else if (wrCc)
    begin
      ccRate <= regWdata[`FRP_RATE_HI:`FRP_RATE_LO];
      ccLast <= 1'b1; // [RULE2]
    end
    if (wrCtrl)
      fifoEnable <= regWdata[0]; // [RULE12]
    else if (softReset)
      fifoEnable <= 1'b0; // [RULE12]
  end
end

// Outside compatibility modes the rate control register alone decides.
wire [1:0] effRate = (compatMode && ccLast) ? ccRate : rateReg; // [RULE2]
wire tapeNow = (effRate == `FRP_RATE_300) && (driveRateCfg == `FRP_DRT_TAPE); // [RULE8]
wire [15:0] delayNow;
wire pcOnNow;

frp_code_a_calc uCalc
(
  .code(codeA),
  .rateSel(effRate),
  .tapeRate(tapeNow),
  .delayPs(delayNow),
  .precompOn(pcOnNow)
);

always @(posedge clk_sys or negedge arst_n)
begin
  if (!arst_n)
  begin
    rateSelect <= `FRP_RATE_250;
    reduced_write_current_n <= 1'b0;
    tapeRateOn <= 1'b0;
    precompDelayPs <= 16'h0000;
    precompEnable <= 1'b0;
  end
  else
  begin
    rateSelect <= effRate; // [RULE6]
    reduced_write_current_n <= (effRate == `FRP_RATE_500) || (effRate == `FRP_RATE_1M); // [RULE7]
    tapeRateOn <= tapeNow; // [RULE8]
    precompDelayPs <= delayNow; // [RULE9]
    precompEnable <= pcOnNow; // [RULE10]
  end
end

////////////////////////////////////////////////////////////////////////////////
// Status zero assembly.

reg [1:0] icField;
reg seekEnd;
reg equipCheck;
reg [6:0] stepCount;

always @(posedge clk_sys or negedge arst_n)
begin
  if (!arst_n)
  begin
    icField <= `FRP_IC_NORMAL;
    seekEnd <= 1'b0;
    equipCheck <= 1'b0;
    stepCount <= 7'h00;
  end
  else
  begin
    icField <= intCode; // [RULE13]
    if (seekDone)
      seekEnd <= seekOk; // [RULE15]
    if (cmdStart)
      stepCount <= 7'h00;
    else if (stepPulse && !trackZeroS && stepCount != `FRP_STEP_LIMIT)
      stepCount <= stepCount + 7'h01;
    // Set wins over the clear at command start.
    if (faultS || (stepCount == `FRP_STEP_LIMIT && !trackZeroS)) // [RULE14]
      equipCheck <= 1'b1;
    else if (cmdStart)
      equipCheck <= 1'b0;
  end
end

wire [7:0] statusZero = {icField, seekEnd, equipCheck, !readyS, headSel, unitSel}; // [RULE13] [RULE15] [RULE16] [RULE17]

////////////////////////////////////////////////////////////////////////////////
// Result stack behind the data port.

reg [7:0] stack [0:`FRP_STACK_DEPTH-1];
reg [`FRP_STACK_AW-1:0] topIdx;
reg [`FRP_STACK_AW:0] fill;

wire rdData = regRd && isAddr(regAddr, `FRP_OFF_DATA);
wire wrData = regWr && isAddr(regAddr, `FRP_OFF_DATA);
wire popOk = rdData && fifoEnable && (fill != 3'h0);
wire pushOk = resultPush && (fill != 3'h4);
// The write slot wraps inside the stack; a wider sum would miss slot zero.
wire [`FRP_STACK_AW-1:0] pushIdx = topIdx + fill[`FRP_STACK_AW-1:0];

genvar gi;
generate
  for (gi = 0; gi < `FRP_STACK_DEPTH; gi = gi + 1)
  begin : gStack
    always @(posedge clk_sys or negedge arst_n)
    begin
      if (!arst_n)
        stack[gi] <= 8'h00;
      else if (pushOk && pushIdx == gi)
        stack[gi] <= resultByte; // [RULE11]
    end
  end
endgenerate

always @(posedge clk_sys or negedge arst_n)
begin
  if (!arst_n)
  begin
    topIdx <= 2'h0;
    fill <= 3'h0;
    cmdByte <= 8'h00;
    cmdValid <= 1'b0;
  end
  else
  begin
    if (popOk)
      topIdx <= topIdx + 2'h1; // [RULE11]
    if (softReset)
      fill <= 3'h0;
    else if (pushOk && !popOk)
      fill <= fill + 3'h1;
    else if (popOk && !pushOk)
      fill <= fill - 3'h1;
    cmdValid <= wrData && fifoEnable; // [RULE12]
    if (wrData)
      cmdByte <= regWdata; // [RULE11]
  end
end

////////////////////////////////////////////////////////////////////////////////
// Read data, valid only the cycle after the strobe.

wire [7:0] mainStatus = {fifoEnable && !engineBusy, fill != 3'h0, 1'b0, engineBusy, 4'h0};

always @(posedge clk_sys or negedge arst_n)
begin
  if (!arst_n)
    regRdata <= 8'h00;
  else if (!regRd)
    regRdata <= 8'h00;
  else if (isAddr(regAddr, `FRP_OFF_RATE))
    regRdata <= mainStatus; // [RULE18]
  else if (isAddr(regAddr, `FRP_OFF_DATA))
    regRdata <= (fifoEnable && fill != 3'h0) ? stack[topIdx] : 8'h00; // [RULE11]
  else if (isAddr(regAddr, `FRP_OFF_STAT0))
    regRdata <= statusZero; // [RULE13]
  else if (isAddr(regAddr, `FRP_OFF_CTRL))
    regRdata <= {7'h00, fifoEnable};
  else
    regRdata <= 8'h00;
end

endmodule // frp_rate_regs

// ### frp_rate_regs_monitor.sv
/*
  Concurrent checks on the ports of the rate register block.
  Assumes it is bound into frp_rate_regs and shares its clock and reset.
*/
`timescale 1ns/1ps
module frp_rate_regs_monitor
(
  // Clock, reset and inputs.
  input wire clk_sys,
  input wire arst_n,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire compatMode,
  // Outputs.
  input wire [7:0] regRdata,
  input wire reduced_write_current_n,
  input wire [1:0] rateSelect,
  input wire tapeRateOn,
  input wire powerDown,
  input wire softReset,
  input wire precompEnable,
  input wire cmdValid
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  wire rateWr = regWr && regAddr == 3'h4 && !regWdata[7] && !compatMode;
  ////////////////////////////////////////////////////////////////////////
  rwc_from_rate_a: assert property (reduced_write_current_n == (rateSelect == 2'h0 || rateSelect == 2'h3))
    else $error("write current level does not match rate");
  soft_pulse_a: assert property (softReset |=> !softReset)
    else $error("soft reset longer than one cycle");
  soft_cause_a: assert property (softReset |-> $past(regWr && regAddr == 3'h4 && regWdata[7]))
    else $error("soft reset without a write of bit 7");
  rate_hold_a: assert property ($changed(rateSelect) |-> $past(regWr, 2))
    else $error("rate changed without a write");
  rate_write_a: assert property (rateWr |-> ##2 rateSelect == $past(regWdata[1:0], 2))
    else $error("rate select not taken from write");
  power_down_a: assert property (rateWr |=> powerDown == $past(regWdata[6]))
    else $error("power down not taken from bit 6");
  code_a_off_a: assert property (rateWr && regWdata[4:2] == 3'h7 |-> ##2 !precompEnable)
    else $error("code 111 left precompensation on");
  tape_rate_a: assert property (tapeRateOn |-> rateSelect == 2'h1)
    else $error("tape rate with wrong rate code");
  cmd_cause_a: assert property (cmdValid |-> $past(regWr && regAddr == 3'h5))
    else $error("data byte without a data port write");
  rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside the answer cycle");
  // Main scenarios reached.
  cover property (rateSelect == 2'h3);
  cover property (softReset);
  cover property (tapeRateOn);
  cover property (cmdValid);
endmodule // frp_rate_regs_monitor

bind frp_rate_regs frp_rate_regs_monitor u_mon (.clk_sys(clk_sys), .arst_n(arst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .compatMode(compatMode), .regRdata(regRdata),
  .reduced_write_current_n(reduced_write_current_n), .rateSelect(rateSelect),
  .tapeRateOn(tapeRateOn), .powerDown(powerDown), .softReset(softReset),
  .precompEnable(precompEnable), .cmdValid(cmdValid));

// ### tb_frp_rate_regs.sv
/*
  Self-checking bench for the rate register block with a drive model.
  Assumes a 10 MHz clock and the strobe register port of the block.
*/
`timescale 1ns/1ps
module tb_frp_rate_regs;
  reg clk_sys = 1'b0, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, compatMode = 1'b0;
  reg [2:0] regAddr = 3'h0;
  reg [7:0] regWdata = 8'h00, resultByte = 8'h00;
  reg [1:0] driveRateCfg = 2'h0, intCode = 2'h0, unitSel = 2'h0;
  reg seekDone = 1'b0, seekOk = 1'b0, stepPulse = 1'b0, resultPush = 1'b0;
  reg cmdStart = 1'b0, engineBusy = 1'b0, headSel = 1'b0;
  wire driveFault, driveReady, trackZero, rwcN, tapeRateOn, powerDown, softReset;
  wire precompEnable, cmdValid;
  wire [7:0] regRdata, cmdByte;
  wire [1:0] rateSelect;
  wire [15:0] precompDelayPs;
  integer errors = 0, checkCount = 0, seed = 92697, i, cmdCnt = 0, srCnt = 0;
  reg [7:0] r;
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cmdCnt <= cmdCnt + cmdValid;
    srCnt <= srCnt + softReset;
  end
  frp_rate_regs u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .compatMode(compatMode), .driveRateCfg(driveRateCfg), .intCode(intCode),
    .seekDone(seekDone), .seekOk(seekOk), .stepPulse(stepPulse), .resultPush(resultPush),
    .resultByte(resultByte), .cmdStart(cmdStart), .engineBusy(engineBusy),
    .unitSel(unitSel), .headSel(headSel), .driveFault(driveFault), .driveReady(driveReady),
    .trackZero(trackZero), .reduced_write_current_n(rwcN), .rateSelect(rateSelect),
    .tapeRateOn(tapeRateOn), .powerDown(powerDown), .softReset(softReset),
    .precompDelayPs(precompDelayPs), .precompEnable(precompEnable), .cmdByte(cmdByte),
    .cmdValid(cmdValid));
  frp_drive_model u_drive (.clk_sys(clk_sys), .stepPulse(stepPulse), .unitSel(unitSel),
    .driveReady(driveReady), .driveFault(driveFault), .trackZero(trackZero));
  ////////////////////////////////////////////////////////////////////////
  function expRwc(input [1:0] rate);
    expRwc = (rate == 2'h0) || (rate == 2'h3);
  endfunction
  task chk(input [8*12-1:0] name, input [15:0] exp, input [15:0] got);
    begin
      #1;
      checkCount = checkCount + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // Writes leave three cycles so both rate stages have landed before checks.
  task wr(input [2:0] a, input [7:0] d);
    begin
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  task rd(input [2:0] a, input [7:0] exp);
    begin
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 chk("regRdata", {8'h00, exp}, {8'h00, regRdata});
      @(posedge clk_sys);
    end
  endtask
  task rst_chk;
    begin
      arst_n = 1'b0;
      repeat (20) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("rateSelect", 16'h0002, {14'h0, rateSelect});
      chk("flags", 16'h0001, {12'h0, powerDown, softReset, rwcN, precompEnable});
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", checkCount, errors);
      if (errors == 0 && checkCount > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    #3000000;
    errors = errors + 1;
    finish_test;
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_chk;
    rd(3'h4, 8'h00);
    rd(3'h1, 8'h00);
    wr(3'h5, 8'h33);
    chk("cmdCnt", 16'h0000, cmdCnt[15:0]);
    wr(3'h3, 8'h01);
    rd(3'h4, 8'h80);
    wr(3'h5, 8'h5a);
    chk("cmdByte", {8'h01, 8'h5a}, {cmdCnt[7:0], cmdByte});
    for (i = 0; i < 8; i = i + 1)
    begin
      // Bit 5 is set throughout and must change nothing.
      wr(3'h4, {3'h1, i[2:0], i[1:0]});
      chk("rateSelect", {14'h0, i[1:0]}, {14'h0, rateSelect});
      chk("rwcN", {15'h0, expRwc(i[1:0])}, {15'h0, rwcN});
      chk("precompOn", {15'h0, i != 7}, {15'h0, precompEnable});
    end
    driveRateCfg <= 2'h2;
    wr(3'h4, 8'h05);
    chk("tapeDelay", 16'h0823, precompDelayPs);
    chk("tapeRateOn", 16'h0001, {15'h0, tapeRateOn});
    wr(3'h4, 8'h04);
    chk("delay", 16'h1047, precompDelayPs);
    chk("tapeRateOn", 16'h0000, {15'h0, tapeRateOn});
    wr(3'h4, 8'h42);
    chk("powerDown", 16'h0001, {15'h0, powerDown});
    wr(3'h4, 8'h80);
    chk("srCnt", 16'h0001, srCnt[15:0]);
    rd(3'h4, 8'h00);
    for (i = 0; i < 30; i = i + 1)
    begin
      r = $random(seed) & 8'h7f;
      {intCode, seekDone, seekOk, stepPulse, resultPush, resultByte} <= $random(seed);
      {cmdStart, engineBusy, unitSel, headSel, driveRateCfg} <= $random(seed);
      wr(3'h4, r);
      chk("rateSelect", {14'h0, r[1:0]}, {14'h0, rateSelect});
      chk("rwcN", {15'h0, expRwc(r[1:0])}, {15'h0, rwcN});
    end
    // Drive B, head 1, seek ended well, abnormal code; the start clears old checks.
    {intCode, seekDone, seekOk, stepPulse, resultPush, resultByte} <= 14'h1c00;
    {cmdStart, engineBusy, unitSel, headSel, driveRateCfg} <= 7'h4c;
    repeat (6) @(posedge clk_sys);
    cmdStart <= 1'b0;
    seekDone <= 1'b0;
    rd(3'h6, 8'h65);
    unitSel <= 2'h3;
    repeat (4) @(posedge clk_sys);
    rd(3'h6, 8'h7f);
    {intCode, seekDone, seekOk, stepPulse, resultPush, resultByte} <= 14'h0000;
    {cmdStart, engineBusy, unitSel, headSel, driveRateCfg} <= 7'h00;
    rst_chk;
    wr(3'h3, 8'h01);
    resultByte <= 8'ha1;
    resultPush <= 1'b1;
    @(posedge clk_sys);
    resultByte <= 8'hb2;
    @(posedge clk_sys);
    resultPush <= 1'b0;
    rd(3'h5, 8'ha1);
    rd(3'h5, 8'hb2);
    finish_test;
  end
endmodule // tb_frp_rate_regs
